/* inc/psr_pkg.sv */
// constants shared by the four-stage shift register block
package psr_pkg;
  localparam int STAGES = 4;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] STAGE_RST = 4'h0;
  localparam logic [2:0] SYNC_RST = 3'h0;
  // data, mode and serial pair positions inside a fifo word
  localparam int W_DATA_LSB = 0;
  localparam int W_KN_POS = 4;
  localparam int W_J_POS = 5;
  localparam int W_MODE_POS = 6;
  localparam int WORD_W = 7;
endpackage : psr_pkg

/* rtl/psr_fifo.sv */
// small valid/ready fifo for command words
`timescale 1ns/100ps
`default_nettype none
module psr_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    // a full fifo refuses the word even if a pop frees a slot in the same cycle
    push = in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = (cnt_q != '0) && out_ready;
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
endmodule : psr_fifo
`default_nettype wire

/* rtl/psr_shift_reg.sv */
// four-stage parallel-access shift register with j/k-bar first stage
`timescale 1ns/100ps
`default_nettype none
module psr_shift_reg (
  input wire logic clock,
  input wire logic srst,
  input wire logic clear_n,
  input wire logic shift_not_load,
  input wire logic serial_j,
  input wire logic serial_k_n,
  input wire logic [psr_pkg::STAGES-1:0] par_in,
  input wire logic step_valid,
  output logic step_ready,
  output logic stage1_out,
  output logic stage2_out,
  output logic stage3_out,
  output logic stage4_out,
  output logic stage4_out_n
);
  import psr_pkg::*;
  // clear arrives from a pin: three-flop synchroniser, acts once flops 2 and 3 agree
  logic [2:0] clr_sync_q;
  logic clr_act_q, clr_act_d;
  // a step request (one rising register edge) is queued with its inputs
  logic [WORD_W-1:0] word_in, word_out;
  logic f_valid, f_ready;
  logic [STAGES-1:0] st_q, st_d;
  logic stn_q, stn_d;
  logic mode, jj, kn;
  logic [STAGES-1:0] pin;

  assign word_in = {shift_not_load, serial_j, serial_k_n, par_in};

  psr_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_valid(step_valid),
    .in_ready(step_ready),
    .in_data(word_in),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(word_out)
  );

  always_comb begin
    mode = word_out[W_MODE_POS];
    jj = word_out[W_J_POS];
    kn = word_out[W_KN_POS];
    pin = word_out[W_DATA_LSB +: STAGES];
    clr_act_d = clr_act_q;
    if (clr_sync_q[1] == clr_sync_q[2]) begin
      clr_act_d = ~clr_sync_q[2];
    end
    // steps drain only while clear is inactive; during clear they wait
    f_ready = ~clr_act_d;
    st_d = st_q;
    if (clr_act_d) begin
      st_d = STAGE_RST;
    end else if (f_valid) begin
      if (!mode) begin
        st_d = pin;
      end else begin
        st_d[STAGES-1:1] = st_q[STAGES-2:0];
        unique case ({jj, kn})
          2'b01: st_d[0] = st_q[0];
          2'b00: st_d[0] = 1'b0;
          2'b11: st_d[0] = 1'b1;
          2'b10: st_d[0] = ~st_q[0];
        endcase
      end
    end
    stn_d = ~st_d[STAGES-1];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      clr_sync_q <= SYNC_RST;
      clr_act_q <= 1'b1;
      st_q <= STAGE_RST;
      stn_q <= 1'b1;
    end else begin
      clr_sync_q <= {clr_sync_q[1:0], clear_n};
      clr_act_q <= clr_act_d;
      st_q <= st_d;
      stn_q <= stn_d;
    end
  end

  assign stage1_out = st_q[0];
  assign stage2_out = st_q[1];
  assign stage3_out = st_q[2];
  assign stage4_out = st_q[3];
  assign stage4_out_n = stn_q;

  AST_CLEAR_FORCES: assert property (@(posedge clock) disable iff (srst)
    clr_act_q |-> (st_q == STAGE_RST) && stn_q) else $error("clear did not force stages");
  AST_INV_OUT: assert property (@(posedge clock) disable iff (srst)
    stn_q == ~st_q[STAGES-1]) else $error("inverted output mismatch");
  AST_LOAD: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && !mode) |=> st_q == $past(pin)) else $error("load failed");
  AST_SHIFT: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && mode) |=> st_q[3:1] == $past(st_q[2:0]))
    else $error("shift failed");
  AST_TOGGLE: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && mode && jj && !kn) |=> st_q[0] != $past(st_q[0]))
    else $error("toggle failed");
  AST_SET: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && mode && jj && kn) |=> st_q[0]) else $error("set failed");
  AST_HOLD: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && !f_valid) |=> $stable(st_q) && $stable(stn_q)) else $error("hold failed");
  // serial pair is random during loads, so any leak shows up on stage one
  AST_LOAD_NOSER: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && !mode) |=> st_q[0] == $past(pin[0]))
    else $error("serial leaked into load");
  AST_SER_LOW: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && mode && !jj && !kn) |=> !st_q[0])
    else $error("serial low failed");
  AST_SER_HOLD: assert property (@(posedge clock) disable iff (srst)
    (!clr_act_d && f_valid && mode && !jj && kn) |=> st_q[0] == $past(st_q[0]))
    else $error("serial hold failed");
  // queued steps must wait while clear is active, otherwise they would be lost
  AST_CLEAR_STALL: assert property (@(posedge clock) disable iff (srst)
    clr_act_d |-> !f_ready) else $error("fifo drained during clear");
endmodule : psr_shift_reg
`default_nettype wire

/* bench/psr_host_drv.sv */
// random step requests from the surrounding logic
`timescale 1ns/100ps
`default_nettype none
module psr_host_drv (
  input wire logic clock,
  input wire logic run,
  output logic step_valid,
  output logic shift_not_load,
  output logic serial_j,
  output logic serial_k_n,
  output logic [3:0] par_in
);
  int seed = 74481;
  initial begin
    {step_valid, shift_not_load, serial_j, serial_k_n, par_in} = 8'h00;
    forever begin
      @(negedge clock);
      // fields move off the rising edge only
      {shift_not_load, serial_j, serial_k_n, par_in} = 7'($random(seed));
      step_valid = run & 1'($random(seed));
    end
  end
endmodule : psr_host_drv
`default_nettype wire

/* bench/four_bit_parallel_access_shift_register_tb_top.sv */
// bench for the four-stage shift register
`timescale 1ns/100ps
`default_nettype none
module four_bit_parallel_access_shift_register_tb_top;
  import psr_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clear_n = 1'b0;
  logic run = 1'b0;
  logic stream = 1'b0;
  logic step_valid, step_ready, shift_not_load, serial_j, serial_k_n, st_n;
  logic [3:0] par_in, st;
  logic [3:0] model = 4'h0;
  logic [3:0] exp_q[$];
  logic [1:0] due = 2'h0;
  int mismatches = 0;
  int checks = 0;
  psr_shift_reg i_dut (.clock(clock), .srst(srst), .clear_n(clear_n),
    .shift_not_load(shift_not_load), .serial_j(serial_j), .serial_k_n(serial_k_n),
    .par_in(par_in), .step_valid(step_valid), .step_ready(step_ready),
    .stage1_out(st[0]), .stage2_out(st[1]), .stage3_out(st[2]), .stage4_out(st[3]),
    .stage4_out_n(st_n));
  psr_host_drv i_host (.clock(clock), .run(run), .step_valid(step_valid),
    .shift_not_load(shift_not_load), .serial_j(serial_j), .serial_k_n(serial_k_n),
    .par_in(par_in));
  initial begin
    forever #4 clock = ~clock;
  end
  task cmp_state(input logic [3:0] e);
    checks++;
    if ({st_n, st} !== {~e[3], e}) begin
      mismatches++;
      $display("BAD %0t stages %h want %h", $time, st, e);
    end
  endtask : cmp_state
  task finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // j with k-bar acts as a jk flop on the first stage
  function automatic logic [3:0] nxt(logic [3:0] s, logic m, logic j, logic kn, logic [3:0] p);
    if (!m) return p;
    return {s[2:0], (j & ~s[0]) | (kn & s[0])};
  endfunction : nxt
  always @(posedge clock) begin
    if (step_valid && step_ready) begin
      model = nxt(model, shift_not_load, serial_j, serial_k_n, par_in);
      exp_q.push_back(model);
    end
    due <= {due[0], stream & step_valid & step_ready};
    if (due[1]) cmp_state(exp_q.pop_front());
  end
  initial begin
    repeat (8) @(negedge clock);
    srst = 1'b0;
    clear_n = 1'b1;
    repeat (5) @(negedge clock);
    run = 1'b1;
    stream = 1'b1;
    repeat (400) @(negedge clock);
    run = 1'b0;
    stream = 1'b0;
    repeat (4) @(negedge clock);
    exp_q.delete();
    clear_n = 1'b0;
    repeat (5) @(negedge clock);
    cmp_state(4'h0);
    model = 4'h0;
    run = 1'b1;
    // a held clear stalls the fifo so it fills to refusal
    for (int i = 0; i < 60 && step_ready !== 1'b0; i++) @(negedge clock);
    run = 1'b0;
    if (step_ready !== 1'b0) begin
      mismatches++;
      $display("BAD %0t fifo never filled", $time);
      finish_test();
    end
    repeat (4) @(negedge clock);
    clear_n = 1'b1;
    repeat (20) @(negedge clock);
    cmp_state(model);
    finish_test();
  end
endmodule : four_bit_parallel_access_shift_register_tb_top
`default_nettype wire
